// ===== pkg/utopia_user_pkg.sv
package utopia_user_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int BYTE_W = 8;
	localparam int WORD_W = 16;
	localparam int INDEX_W = 5;
	localparam int POS_W = 6;

	// ****************************************
	// Cell layout
	// ****************************************
	// Word positions run 0x00 to 0x1A; the index shows 0x1B once the cell is whole.
	localparam logic [INDEX_W-1:0] LAST_INDEX = 5'h1B;
	// Fifth header byte, copied into the sixth in short-cell mode.
	localparam logic [POS_W-1:0] COPY_POS = 6'h04;
	// Position that follows the copied byte.
	localparam logic [POS_W-1:0] AFTER_COPY_POS = 6'h06;
	// Last of the 54 user byte positions.
	localparam logic [POS_W-1:0] LAST_POS = 6'h35;

	// ****************************************
	// States
	// ****************************************
	typedef enum logic {
		TX_WAIT = 1'b0,
		TX_CELL = 1'b1
	} tx_state_type;

	typedef enum logic {
		RX_IDLE = 1'b0,
		RX_SEND = 1'b1
	} rx_state_type;

endpackage

// ===== pkg/utopia_user_if.sv
interface utopia_user_if;

	// Write side, core to user logic.
	logic write_space_ready;
	logic write_port_selected;
	logic write_word_strobe;
	logic [utopia_user_pkg::INDEX_W-1:0] write_word_index;
	logic [utopia_user_pkg::WORD_W-1:0] write_word_bus;

	// Read side, user logic to core.
	logic read_cell_ready;
	logic read_word_request;
	logic [utopia_user_pkg::INDEX_W-1:0] read_word_index;
	logic [utopia_user_pkg::WORD_W-1:0] read_word_bus;

	// The cell core end.
	modport phy_end (
		input write_space_ready,
		output write_port_selected,
		output write_word_strobe,
		output write_word_index,
		output write_word_bus,
		input read_cell_ready,
		output read_word_request,
		output read_word_index,
		input read_word_bus
	);

	// The cell buffer or user logic end.
	modport user_end (
		output write_space_ready,
		input write_port_selected,
		input write_word_strobe,
		input write_word_index,
		input write_word_bus,
		output read_cell_ready,
		input read_word_request,
		input read_word_index,
		output read_word_bus
	);

endinterface

// ===== design/utopia_user_end.sv
module utopia_user_end (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_in,
	// Core side.
	utopia_user_if.user_end port_if,
	// Write side toward the user.
	input wire logic wr_space_in,
	output logic wr_selected_out,
	output logic wr_valid_out,
	output logic [utopia_user_pkg::WORD_W-1:0] wr_word_out,
	output logic [utopia_user_pkg::INDEX_W-1:0] wr_index_out,
	output logic wr_cell_done_out,
	output logic wr_cell_drop_out,
	// Read side from the user.
	input wire logic rd_cell_ready_in,
	input wire logic ld_write_in,
	input wire logic [utopia_user_pkg::INDEX_W-1:0] ld_index_in,
	input wire logic [utopia_user_pkg::WORD_W-1:0] ld_word_in
);

	// ****************************************
	// Write side
	// ****************************************

	// Previous strobe and index, used to find events once per link cycle.
	logic strobe_prev;
	logic [utopia_user_pkg::INDEX_W-1:0] index_prev;

	// Readiness goes straight to the core, which shows it to the link.
	assign port_if.write_space_ready = wr_space_in;
	assign wr_selected_out = port_if.write_port_selected;

	// History of the core outputs.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			strobe_prev <= 1'b0;
			index_prev <= '0;
		end else begin
			strobe_prev <= port_if.write_word_strobe;
			index_prev <= port_if.write_word_index;
		end
	end

	// A new word stands on the first clock of a strobe. In short-cell mode the
	// strobe stays high across the copied header byte, so a moving index under a
	// held strobe also marks a new word; without it that word would be lost.
	logic take_word;

	assign take_word = port_if.write_word_strobe &&
		(!strobe_prev || (port_if.write_word_index != index_prev));

	// Each word is taken once, with the index it was delivered under.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wr_valid_out <= 1'b0;
			wr_word_out <= '0;
			wr_index_out <= '0;
		end else begin
			wr_valid_out <= take_word;
			if (take_word) begin
				wr_word_out <= port_if.write_word_bus;
				wr_index_out <= port_if.write_word_index;
			end
		end
	end

	// Cell end and cell loss are read from the index alone.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wr_cell_done_out <= 1'b0;
			wr_cell_drop_out <= 1'b0;
		end else begin
			// Reaching the last index means a whole cell arrived.
			wr_cell_done_out <= (port_if.write_word_index == utopia_user_pkg::LAST_INDEX) &&
				(index_prev != utopia_user_pkg::LAST_INDEX);
			// An early return to zero means the words so far must be dropped.
			wr_cell_drop_out <= (port_if.write_word_index == '0) && (index_prev != '0) &&
				(index_prev != utopia_user_pkg::LAST_INDEX);
		end
	end

	// ****************************************
	// Read side
	// ****************************************

	// One cell of words, loaded by the user before it raises ready.
	logic [utopia_user_pkg::WORD_W-1:0] cell_mem [0:26];
	// Data word toward the core.
	logic [utopia_user_pkg::WORD_W-1:0] read_word;

	assign port_if.read_cell_ready = rd_cell_ready_in;
	assign port_if.read_word_bus = read_word;

	// The store has no reset; its words are undefined until loaded.
	always_ff @(posedge clock_in) begin
		if (ld_write_in && (ld_index_in < utopia_user_pkg::LAST_INDEX)) begin
			cell_mem[ld_index_in] <= ld_word_in;
		end
	end

	// The word follows the index on every clock while the index is below 0x1B, far sooner than the link edge.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			read_word <= '0;
		end else if (port_if.read_word_index < utopia_user_pkg::LAST_INDEX) begin
			read_word <= cell_mem[port_if.read_word_index];
		end
	end

endmodule // utopia_user_end

// ===== design/utopia_phy_cell_user_port.sv
module utopia_phy_cell_user_port (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_in,
	// Cell size: low for 53-byte link cells, high for 54.
	input wire logic cell_size_select_in,
	// Ingress link.
	input wire logic tx_link_clock_in,
	input wire logic tx_select_n_in,
	input wire logic tx_cell_start_in,
	input wire logic [utopia_user_pkg::BYTE_W-1:0] tx_data_in,
	output logic tx_cell_available_out,
	// Egress link.
	input wire logic rx_link_clock_in,
	input wire logic rx_select_n_in,
	output logic rx_cell_start_out,
	output logic [utopia_user_pkg::BYTE_W-1:0] rx_data_out,
	output logic rx_cell_available_out,
	// User side.
	utopia_user_if.phy_end port_if
);

	// ****************************************
	// Pin synchronisers
	// ****************************************

	// Ingress vector: clock, select, start, data.
	localparam int TX_VEC_W = utopia_user_pkg::BYTE_W + 3;
	// Egress vector: clock, select, size.
	localparam int RX_VEC_W = 3;

	// First stages are read only by the second stages.
	logic [TX_VEC_W-1:0] tx_meta;
	logic [TX_VEC_W-1:0] tx_sync;
	logic [TX_VEC_W-1:0] tx_prev;
	logic [RX_VEC_W-1:0] rx_meta;
	logic [RX_VEC_W-1:0] rx_sync;
	logic [RX_VEC_W-1:0] rx_prev;

	// The third stage holds values from before the edge, so data that changes
	// just after the link edge is never taken by mistake.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			tx_meta <= '0;
			tx_sync <= '0;
			tx_prev <= '0;
			rx_meta <= '0;
			rx_sync <= '0;
			rx_prev <= '0;
		end else begin
			tx_meta <= {tx_link_clock_in, tx_select_n_in, tx_cell_start_in, tx_data_in};
			tx_sync <= tx_meta;
			tx_prev <= tx_sync;
			rx_meta <= {rx_link_clock_in, rx_select_n_in, cell_size_select_in};
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	// One-cycle enables at each rising link clock edge.
	logic tx_tick;
	logic rx_tick;
	// Sampled pins, as they stood at the edge.
	logic tx_sel_n;
	logic tx_start;
	logic [utopia_user_pkg::BYTE_W-1:0] tx_byte;
	logic rx_sel_n;
	logic short_cells;

	assign tx_tick = tx_sync[TX_VEC_W-1] && !tx_prev[TX_VEC_W-1];
	assign rx_tick = rx_sync[RX_VEC_W-1] && !rx_prev[RX_VEC_W-1];
	assign tx_sel_n = tx_prev[TX_VEC_W-2];
	assign tx_start = tx_prev[TX_VEC_W-3];
	assign tx_byte = tx_prev[utopia_user_pkg::BYTE_W-1:0];
	assign rx_sel_n = rx_prev[1];
	assign short_cells = !rx_prev[0];

	// ****************************************
	// Cell available
	// ****************************************

	// Each flag follows the user readiness on its own link clock.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			tx_cell_available_out <= 1'b0;
			rx_cell_available_out <= 1'b0;
		end else begin
			if (tx_tick) begin
				tx_cell_available_out <= port_if.write_space_ready;
			end
			if (rx_tick) begin
				rx_cell_available_out <= port_if.read_cell_ready;
			end
		end
	end

	// ****************************************
	// Ingress: bytes to words
	// ****************************************

	utopia_user_pkg::tx_state_type tx_state;
	// Next user byte position expected.
	logic [utopia_user_pkg::POS_W-1:0] tx_pos;
	// Upper byte waiting for its partner.
	logic [utopia_user_pkg::BYTE_W-1:0] tx_upper;
	// The copied header byte lands in the same word as the fifth one.
	logic copy_now;

	assign copy_now = short_cells && (tx_pos == utopia_user_pkg::COPY_POS);

	// Selection flag: set on any selected edge, cleared only by deselection.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			port_if.write_port_selected <= 1'b0;
		end else if (tx_tick) begin
			port_if.write_port_selected <= !tx_sel_n;
		end
	end

	// Cell progress and word assembly.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			tx_state <= utopia_user_pkg::TX_WAIT;
			tx_pos <= '0;
			tx_upper <= '0;
			port_if.write_word_strobe <= 1'b0;
			port_if.write_word_index <= '0;
			port_if.write_word_bus <= '0;
		end else if (tx_tick) begin
			// Each word's strobe lasts one link cycle; the index moves on the edge after it.
			if (port_if.write_word_strobe) begin
				port_if.write_word_strobe <= 1'b0;
				port_if.write_word_index <= port_if.write_word_index + 1'b1;
			end else if (port_if.write_word_index == utopia_user_pkg::LAST_INDEX) begin
				port_if.write_word_index <= '0;
			end
			if (tx_sel_n) begin
				// Deselection inside a cell aborts it; the index drops to zero.
				if (tx_state == utopia_user_pkg::TX_CELL) begin
					tx_state <= utopia_user_pkg::TX_WAIT;
					port_if.write_word_strobe <= 1'b0;
					port_if.write_word_index <= '0;
				end
			end else if (tx_start) begin
				// Start may come on the very edge that selects the port.
				if (tx_state == utopia_user_pkg::TX_CELL) begin
					port_if.write_word_strobe <= 1'b0;
					port_if.write_word_index <= '0;
				end
				tx_state <= utopia_user_pkg::TX_CELL;
				tx_upper <= tx_byte;
				tx_pos <= 6'h01;
			end else if (tx_state == utopia_user_pkg::TX_CELL) begin
				unique case (tx_pos[0])
					1'b0: begin
						tx_upper <= tx_byte;
						if (copy_now) begin
							// The fifth byte fills both halves; no gap follows the word before.
							port_if.write_word_bus <= {tx_byte, tx_byte};
							port_if.write_word_strobe <= 1'b1;
							tx_pos <= utopia_user_pkg::AFTER_COPY_POS;
						end else begin
							tx_pos <= tx_pos + 1'b1;
						end
					end
					1'b1: begin
						port_if.write_word_bus <= {tx_upper, tx_byte};
						port_if.write_word_strobe <= 1'b1;
						if (tx_pos == utopia_user_pkg::LAST_POS) begin
							tx_state <= utopia_user_pkg::TX_WAIT;
						end else begin
							tx_pos <= tx_pos + 1'b1;
						end
					end
				endcase
			end
		end
	end

	// ****************************************
	// Egress: words to bytes
	// ****************************************

	utopia_user_pkg::rx_state_type rx_state;
	// User byte position sent on this edge.
	logic [utopia_user_pkg::POS_W-1:0] rx_pos;
	// Lower byte of the word last captured.
	logic [utopia_user_pkg::BYTE_W-1:0] rx_lower;
	// Short mode skips the sixth byte and needs the next word at once.
	logic skip_now;
	// A new cell may follow without a gap.
	logic may_start;

	assign skip_now = short_cells && (rx_pos == utopia_user_pkg::COPY_POS);
	assign may_start = port_if.read_cell_ready && !rx_sel_n;

	// Fetch and send. Requests fall on odd positions and, in short mode, on the fifth, so each word arrives as
	// its upper byte is due; deselection is not looked at inside a cell.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rx_state <= utopia_user_pkg::RX_IDLE;
			rx_pos <= '0;
			rx_lower <= '0;
			rx_data_out <= '0;
			rx_cell_start_out <= 1'b0;
			port_if.read_word_request <= 1'b0;
			port_if.read_word_index <= '0;
		end else if (rx_tick) begin
			unique case (rx_state)
				utopia_user_pkg::RX_IDLE: begin
					rx_cell_start_out <= 1'b0;
					if (may_start) begin
						rx_state <= utopia_user_pkg::RX_SEND;
						port_if.read_word_request <= 1'b1;
						port_if.read_word_index <= '0;
						rx_pos <= '0;
					end
				end
				utopia_user_pkg::RX_SEND: begin
					// The requested word is taken on the edge after the request.
					if (port_if.read_word_request) begin
						rx_data_out <= port_if.read_word_bus[15:8];
						rx_lower <= port_if.read_word_bus[7:0];
						port_if.read_word_index <= port_if.read_word_index + 1'b1;
					end else begin
						rx_data_out <= rx_lower;
					end
					rx_cell_start_out <= (rx_pos == '0);
					port_if.read_word_request <= (rx_pos[0] && (rx_pos != utopia_user_pkg::LAST_POS)) ||
						skip_now;
					if (skip_now) begin
						rx_pos <= utopia_user_pkg::AFTER_COPY_POS;
					end else begin
						rx_pos <= rx_pos + 1'b1;
					end
					if (rx_pos == utopia_user_pkg::LAST_POS) begin
						port_if.read_word_index <= '0;
						if (may_start) begin
							port_if.read_word_request <= 1'b1;
							rx_pos <= '0;
						end else begin
							rx_state <= utopia_user_pkg::RX_IDLE;
						end
					end
				end
			endcase
		end
	end

endmodule // utopia_phy_cell_user_port

// ===== test/utopia_user_sva.sv
module utopia_user_sva (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_in,
	// Write side of the user interface.
	input wire logic write_port_selected,
	input wire logic write_word_strobe,
	input wire logic [4:0] write_word_index,
	// Read side of the user interface.
	input wire logic read_cell_ready,
	input wire logic read_word_request,
	input wire logic [4:0] read_word_index
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	// ****************
	// Sequences
	// ****************
	// A link cycle spans about eight system clocks; six leaves room for edge jitter.
	sequence strobe_pulse;
		write_word_strobe [*6] ##[1:12] !write_word_strobe;
	endsequence
	// After a whole cell the strobe rests while the index shows the end, then clears.
	sequence cell_end;
		(!write_word_strobe) [*6] ##[1:6] (write_word_index == 5'h00);
	endsequence

	// ****************
	// Write side
	// ****************
	chk_strobe_width: assert property ($rose(write_word_strobe) |-> strobe_pulse)
		else $error("write strobe width wrong");
	chk_strobe_index: assert property (
		$fell(write_word_strobe) |->
		(write_word_index != $past(write_word_index)) || (write_word_index == 5'h00))
		else $error("write index did not advance");
	chk_index_step: assert property (
		$changed(write_word_index) |-> (write_word_index == 5'h00) ||
		(write_word_index == $past(write_word_index) + 5'h01))
		else $error("write index skipped");
	chk_strobe_sel: assert property (write_word_strobe |-> write_port_selected)
		else $error("strobe while not selected");
	chk_cell_end: assert property ($rose(write_word_index == 5'h1B) |-> cell_end)
		else $error("cell end handling wrong");

	// ****************
	// Read side
	// ****************
	chk_req_width: assert property ($rose(read_word_request) |-> read_word_request [*6])
		else $error("request too short");
	chk_req_gap: assert property (
		$fell(read_word_request) && (read_word_index != 5'h1B) |->
		(!read_word_request) [*6] ##[1:6] read_word_request)
		else $error("request gap wrong");
	chk_rd_step: assert property (
		$changed(read_word_index) && (read_word_index != 5'h00) |->
		(read_word_index == $past(read_word_index) + 5'h01) && $past(read_word_request))
		else $error("read index step wrong");
	chk_req_ready: assert property (
		$rose(read_word_request) && (read_word_index == 5'h00) |-> $past(read_cell_ready))
		else $error("fetch began without ready");
endmodule // utopia_user_sva

// ===== test/utopia_phy_cell_user_port_bench.sv
module utopia_phy_cell_user_port_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************
	// Signals
	// ****************
	logic clock_in = 1'h0; // System clock.
	logic rst_in = 1'h1; // Reset, active high.
	logic size_sel = 1'h1; // High carries 54-byte link cells.
	logic tx_clk = 1'h0; // Link clocks, free running.
	logic rx_clk = 1'h0;
	logic tx_sel_n = 1'h1; // Ingress link pins.
	logic tx_soc = 1'h0;
	logic [7:0] tx_data = 8'h00;
	logic rx_sel_n = 1'h1; // Egress select.
	logic wr_space = 1'h0; // User readiness.
	logic rd_ready = 1'h0;
	logic ld_write = 1'h0; // Read cell store loading.
	logic [4:0] ld_index = 5'h00;
	logic [15:0] ld_word = 16'h0000;
	logic tx_clav, rx_clav, rx_soc, wr_sel, wr_valid, wr_done, wr_drop; // Observed.
	logic [7:0] rx_data;
	logic [15:0] wr_word;
	logic [4:0] wr_index;
	logic [15:0] wr_got [27]; // Latest cell as seen by the user.
	logic [15:0] reset_view; // Control register outputs that reset must clear; the data buses are not included.
	int n_words, n_done, n_drop, failures, n_checks, m;

	always #5 clock_in = ~clock_in;
	// Odd offsets keep the link clocks out of phase with the system clock.
	initial #3 forever #40 tx_clk = ~tx_clk;
	initial #17 forever #40 rx_clk = ~rx_clk;

	assign reset_view = {port_if.write_port_selected, port_if.write_word_strobe,
		port_if.write_word_index, port_if.read_word_request, port_if.read_word_index,
		rx_soc, tx_clav, rx_clav};

	// ****************
	// Both ends and the checker
	// ****************
	utopia_user_if port_if ();
	utopia_phy_cell_user_port u_utopia_phy_cell_user_port (
		.clock_in(clock_in), .rst_in(rst_in), .cell_size_select_in(size_sel),
		.tx_link_clock_in(tx_clk), .tx_select_n_in(tx_sel_n), .tx_cell_start_in(tx_soc),
		.tx_data_in(tx_data), .tx_cell_available_out(tx_clav), .rx_link_clock_in(rx_clk),
		.rx_select_n_in(rx_sel_n), .rx_cell_start_out(rx_soc), .rx_data_out(rx_data),
		.rx_cell_available_out(rx_clav), .port_if(port_if));
	utopia_user_end u_utopia_user_end (
		.clock_in(clock_in), .rst_in(rst_in), .port_if(port_if), .wr_space_in(wr_space),
		.wr_selected_out(wr_sel), .wr_valid_out(wr_valid), .wr_word_out(wr_word),
		.wr_index_out(wr_index), .wr_cell_done_out(wr_done), .wr_cell_drop_out(wr_drop),
		.rd_cell_ready_in(rd_ready), .ld_write_in(ld_write), .ld_index_in(ld_index),
		.ld_word_in(ld_word));
	utopia_user_sva u_utopia_user_sva (
		.clock_in(clock_in), .rst_in(rst_in),
		.write_port_selected(port_if.write_port_selected),
		.write_word_strobe(port_if.write_word_strobe),
		.write_word_index(port_if.write_word_index), .read_cell_ready(port_if.read_cell_ready),
		.read_word_request(port_if.read_word_request), .read_word_index(port_if.read_word_index));

	// The user end pulses valid once per word; each word is kept by its index.
	always @(posedge clock_in) begin
		if (wr_valid === 1'h1) begin
			wr_got[wr_index] = wr_word;
			n_words++;
		end
		if (wr_done === 1'h1) n_done++;
		if (wr_drop === 1'h1) n_drop++;
	end

	// ****************
	// Tasks
	// ****************
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wrap_up();
		if (failures == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Ingress bytes change at a falling link edge, far from the sampling edge.
	task automatic tx_byte(input logic soc, input logic [7:0] b, input logic sel_n);
		@(negedge tx_clk);
		@(posedge clock_in);
		tx_sel_n <= sel_n;
		tx_soc <= soc;
		tx_data <= b;
	endtask

	// Link byte k of a sent cell is 0x80 plus k.
	task automatic tx_cell(input int n, input logic last_sel_n);
		int k;
		n_words = 0;
		for (k = 0; k < n; k++) tx_byte(k == 0, 8'(8'h80 + k), 1'h0);
		tx_byte(1'h0, 8'h00, last_sel_n);
	endtask

	// In short mode user byte 5 repeats link byte 4 and the rest shift by one.
	function automatic logic [7:0] tx_user(input int i);
		return 8'(8'h80 + ((size_sel || i < 5) ? i : i - 1));
	endfunction

	task automatic tx_verify(input int words, input int dones, input int drops);
		int k;
		repeat (3) @(posedge tx_clk);
		repeat (6) @(posedge clock_in);
		check(16'(n_words), 16'(words), "word count");
		for (k = 0; k < words; k++)
			check(wr_got[k], {tx_user(2 * k), tx_user(2 * k + 1)}, "word");
		check(16'(n_done), 16'(dones), "cells done");
		check(16'(n_drop), 16'(drops), "cells dropped");
	endtask

	// User byte i of the stored cell is 0x40 plus i.
	task automatic load_cell();
		int k;
		for (k = 0; k < 27; k++) begin
			@(posedge clock_in);
			ld_write <= 1'h1;
			ld_index <= 5'(k);
			ld_word <= {8'(8'h40 + 2 * k), 8'(8'h41 + 2 * k)};
		end
		@(posedge clock_in);
		ld_write <= 1'h0;
	endtask

	// In short mode the sixth user byte never reaches the link.
	function automatic logic [7:0] rx_link(input int j);
		return 8'(8'h40 + ((size_sel || j < 5) ? j : j + 1));
	endfunction

	// Takes one egress cell; with now set it must follow the last one with no gap.
	task automatic rx_cell(input int n, input logic now);
		int k;
		int w;
		w = 0;
		@(posedge rx_clk);
		while (!now && rx_soc !== 1'h1 && w < 40) begin
			@(posedge rx_clk);
			w++;
		end
		check({15'h0000, rx_soc}, 16'h0001, "start of cell");
		for (k = 0; k < n; k++) begin
			if (k > 0) @(posedge rx_clk);
			check({8'h00, rx_data}, {8'h00, rx_link(k)}, "egress byte");
		end
	endtask

	// ****************
	// Sequence of tests
	// ****************
	initial begin
		repeat (3) @(posedge clock_in);
		check(reset_view, 16'h0000, "reset");
		repeat (2) @(posedge clock_in);
		rst_in <= 1'h0;
		repeat (4) @(posedge tx_clk);
		check({15'h0000, tx_clav}, 16'h0000, "no space");
		@(posedge clock_in);
		wr_space <= 1'h1;
		repeat (4) @(posedge tx_clk);
		check({15'h0000, tx_clav}, 16'h0001, "space");
		// An aborted cell must be flagged so the user can discard it.
		tx_cell(10, 1'h1);
		tx_verify(5, 0, 1);
		check({15'h0000, wr_sel}, 16'h0000, "deselected");
		tx_cell(54, 1'h0);
		tx_verify(27, 1, 1);
		check({15'h0000, wr_sel}, 16'h0001, "held selected");
		size_sel <= 1'h0;
		tx_cell(53, 1'h0);
		tx_verify(27, 2, 1);
		load_cell();
		size_sel <= 1'h1;
		rd_ready <= 1'h1;
		repeat (4) @(posedge rx_clk);
		check({14'h0000, rx_clav, port_if.read_word_request}, 16'h0002, "unselected");
		// Ready falls as the port is selected, so no cell can start unwatched.
		@(negedge rx_clk);
		@(posedge clock_in);
		rd_ready <= 1'h0;
		rx_sel_n <= 1'h0;
		// Ready drops inside the second cell, which must still complete.
		for (m = 1; m >= 0; m--) begin
			size_sel <= 1'(m);
			repeat (4) @(posedge rx_clk);
			@(posedge clock_in);
			rd_ready <= 1'h1;
			rx_cell(53 + m, 1'h0);
			@(posedge clock_in);
			rd_ready <= 1'h0;
			rx_cell(53 + m, 1'h1);
			@(posedge rx_clk);
			check({15'h0000, rx_soc}, 16'h0000, "no further cell");
			@(posedge clock_in);
		end
		// Both sides are selected here, so reset has real state to clear.
		rst_in <= 1'h1;
		repeat (3) @(posedge clock_in);
		check(reset_view, 16'h0000, "second reset");
		wrap_up();
	end

	// The tests need well under a fifth of this span.
	initial begin
		#300000;
		failures++;
		wrap_up();
	end
endmodule // utopia_phy_cell_user_port_bench
